/* File: design/nbs_pkg.sv */
// package: register map, field layout, reset values and counts of the nine-bit serial port
package nbs_pkg;

	// register byte offsets on the apb bus
	localparam logic [11:0] NBS_CTRL_OFF = 12'h000;
	localparam logic [11:0] NBS_BUF_OFF = 12'h004;
	localparam logic [11:0] NBS_RATE_OFF = 12'h008;
	localparam logic [11:0] NBS_STAT_OFF = 12'h00c;

	// serial_control_register field positions
	localparam int NBS_RX_DONE_BIT = 0;
	localparam int NBS_TX_DONE_BIT = 1;
	localparam int NBS_RX_NINTH_BIT = 2;
	localparam int NBS_TX_NINTH_BIT = 3;
	localparam int NBS_RX_ENABLE_BIT = 4;
	localparam int NBS_FILTER_BIT = 5;
	localparam int NBS_MODE_LO_BIT = 6;
	localparam int NBS_MODE_HI_BIT = 7;

	// rate register field: doubles the bit rate
	localparam int NBS_RATE_DOUBLE_BIT = 0;

	// status register fields
	localparam int NBS_STAT_TX_ACTIVE_BIT = 0;
	localparam int NBS_STAT_RX_ACTIVE_BIT = 1;
	localparam int NBS_STAT_TX_PEND_BIT = 2;

	// reset values
	localparam logic [7:0] NBS_CTRL_RST = 8'h00;
	localparam logic [7:0] NBS_BUF_RST = 8'h00;
	localparam logic NBS_RATE_DOUBLE_RST = 1'b0;

	// sixteen states per bit time
	localparam logic [3:0] NBS_DIV16_LAST = 4'hf;
	// zero-based counter values of the seventh, eighth and ninth states
	localparam logic [3:0] NBS_SAMPLE_FIRST = 4'h6;
	localparam logic [3:0] NBS_SAMPLE_MID = 4'h7;
	localparam logic [3:0] NBS_SAMPLE_LAST = 4'h8;

	// oscillator divider last counts: tick16 at fosc/2 (bit fosc/32) or fosc/4 (bit fosc/64)
	localparam logic [1:0] NBS_OSC_LAST_FAST = 2'h1;
	localparam logic [1:0] NBS_OSC_LAST_SLOW = 2'h3;

	// receive shift register preset and start-bit level
	localparam logic [8:0] NBS_RX_PRESET = 9'h1ff;
	localparam logic NBS_START_LEVEL = 1'b0;
	localparam logic NBS_STOP_LEVEL = 1'b1;

	// receiver states
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} nbs_rx_state_t;

endpackage

/* File: design/nbs_rate_gen.sv */
// sixteen-times bit rate enable from the oscillator or from timer 1 overflows
`timescale 1ns/1ps
module nbs_rate_gen
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic timer_source,
	input wire logic rate_double,
	input wire logic timer1_overflow,
	output logic tick16
);
	import nbs_pkg::*;

	typedef struct packed
	{
		logic [1:0] osc_cnt;
		logic ovf_half;
		logic tick;
	} nbs_rate_state_t;

	nbs_rate_state_t st;
	nbs_rate_state_t next_st;

	// divider: fixed oscillator fraction, or every (second) timer overflow
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (timer_source)
		begin
			next_st.osc_cnt = 2'h0;
			if (timer1_overflow)
			begin
				next_st.ovf_half = ~st.ovf_half;
				next_st.tick = rate_double | st.ovf_half;
			end
		end
		else
		begin
			next_st.ovf_half = 1'b0;
			if (st.osc_cnt >= (rate_double ? NBS_OSC_LAST_FAST : NBS_OSC_LAST_SLOW))
			begin
				next_st.osc_cnt = 2'h0;
				next_st.tick = 1'b1;
			end
			else
			begin
				next_st.osc_cnt = st.osc_cnt + 2'h1;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign tick16 = st.tick;

endmodule

/* File: design/nbs_serial_port.sv */
// nine-bit asynchronous serial port with apb register access
// Function
// - eleven-bit frame: start, eight lsb-first, ninth, stop
// - sent ninth bit comes from tx_ninth_bit
// - oscillator rate is fosc/32 or fosc/64
// - timer rate follows timer 1 overflows
// - buffer write loads ninth bit, requests send
// - sending starts at next divide-by-16 rollover
// - start bit, then data, then first shift
// - first shift inserts stop one, then zeros
// - end pattern: last shift, stop, set done
// - start on falling receive line, 16x sampled
// - falling edge resets counter, presets 1ff
// - majority of samples seven, eight, nine
// - start bit not zero restarts search
// - nine-bit shifter; start leftmost means final shift
// - load only if done clear, filter passes
// - accepted frame fills buffer, ninth, done flag
// - search resumes one bit time later
// - received stop bit value is ignored
// - request is or of both done flags
// - software writes flags like hardware does
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module nbs_serial_port
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer1_overflow,
	input wire logic rxd,
	output logic txd,
	output logic serial_irq
);
	import nbs_pkg::*;

	typedef struct packed
	{
		logic [7:0] ctrl;
		logic rate_double;
		logic [7:0] rx_buf;
		logic [8:0] tx_shift;
		logic tx_pend;
		logic tx_send;
		logic tx_data;
		logic tx_first;
		logic [3:0] tx_cnt;
		logic sync1;
		logic sync2;
		logic sync3;
		logic rx_line;
		logic rx_prev;
		nbs_rx_state_t rx_state;
		logic [3:0] rx_cnt;
		logic [2:0] rx_votes;
		logic [8:0] rx_shift;
		logic txd;
		logic [31:0] rdata;
		logic err;
	} nbs_state_t;

	nbs_state_t st;
	nbs_state_t next_st;
	logic tick16;
	logic setup_phase;
	logic access_wr;

	// majority of three samples
	function automatic logic nbs_major(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// decode of the four mapped offsets
	function automatic logic nbs_mapped(input logic [11:0] a);
		return (a == NBS_CTRL_OFF) || (a == NBS_BUF_OFF) || (a == NBS_RATE_OFF) || (a == NBS_STAT_OFF);
	endfunction

	// reverse a byte so the first received bit lands in bit zero
	function automatic logic [7:0] nbs_rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	// bit rate enable; lower mode bit chooses the timer source
	nbs_rate_gen u_rate
	(
		.pclk(pclk),
		.presetn(presetn),
		.timer_source(st.ctrl[NBS_MODE_LO_BIT]),
		.rate_double(st.rate_double),
		.timer1_overflow(timer1_overflow),
		.tick16(tick16)
	);

	assign setup_phase = psel & ~penable;
	assign access_wr = psel & penable & pwrite;

	// next-state logic: line sampling, transmitter, receiver, registers
	always_comb
	begin
		logic tx_roll;
		logic rx_roll;
		logic bit_val;
		logic ninth;
		logic hw_rx_done;
		logic hw_tx_done;
		logic hw_rx_ninth;
		logic [8:0] fin_shift;
		tx_roll = 1'b0;
		rx_roll = 1'b0;
		bit_val = 1'b0;
		ninth = 1'b0;
		hw_rx_done = 1'b0;
		hw_tx_done = 1'b0;
		hw_rx_ninth = 1'b0;
		fin_shift = 9'h000;
		next_st = st;

		// three-flop pin sampling; a level counts once the last two agree
		next_st.sync1 = rxd;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		if (st.sync2 == st.sync3)
		begin
			next_st.rx_line = st.sync3;
		end

		// transmit divide-by-16 counter, free running on the rate enable
		if (tick16)
		begin
			next_st.tx_cnt = st.tx_cnt + 4'h1;
			tx_roll = (st.tx_cnt == NBS_DIV16_LAST);
		end

		// transmit controller, stepping only on rollovers
		if (tx_roll)
		begin
			if (st.tx_send)
			begin
				if (!st.tx_data)
				begin
					next_st.tx_data = 1'b1;
				end
				else if (!st.tx_first && (st.tx_shift[8:2] == 7'h00) && st.tx_shift[1])
				begin
					next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
					next_st.tx_send = 1'b0;
					next_st.tx_data = 1'b0;
					hw_tx_done = 1'b1;
				end
				else
				begin
					next_st.tx_shift = {st.tx_first, st.tx_shift[8:1]};
					next_st.tx_first = 1'b0;
				end
			end
			else if (st.tx_pend)
			begin
				next_st.tx_send = 1'b1;
				next_st.tx_data = 1'b0;
				next_st.tx_first = 1'b1;
				next_st.tx_pend = 1'b0;
			end
		end

		// receive counter and the three mid-bit samples
		if (tick16)
		begin
			next_st.rx_prev = st.rx_line;
			next_st.rx_cnt = st.rx_cnt + 4'h1;
			rx_roll = (st.rx_cnt == NBS_DIV16_LAST);
			if (st.rx_cnt == NBS_SAMPLE_FIRST)
			begin
				next_st.rx_votes[0] = st.rx_line;
			end
			if (st.rx_cnt == NBS_SAMPLE_MID)
			begin
				next_st.rx_votes[1] = st.rx_line;
			end
			if (st.rx_cnt == NBS_SAMPLE_LAST)
			begin
				next_st.rx_votes[2] = st.rx_line;
			end
		end
		bit_val = nbs_major(st.rx_votes);

		// receive controller
		case (st.rx_state)
			RX_IDLE:
			begin
				if (tick16 && st.ctrl[NBS_RX_ENABLE_BIT] && st.rx_prev && !st.rx_line)
				begin
					next_st.rx_cnt = 4'h1;
					next_st.rx_shift = NBS_RX_PRESET;
					next_st.rx_state = RX_START;
				end
			end
			RX_START:
			begin
				if (rx_roll)
				begin
					if (bit_val != NBS_START_LEVEL)
					begin
						next_st.rx_state = RX_IDLE;
					end
					else
					begin
						next_st.rx_shift = {st.rx_shift[7:0], bit_val};
						next_st.rx_state = RX_DATA;
					end
				end
			end
			RX_DATA:
			begin
				if (rx_roll)
				begin
					fin_shift = {st.rx_shift[7:0], bit_val};
					next_st.rx_shift = fin_shift;
					if (!st.rx_shift[8])
					begin
						ninth = bit_val;
						next_st.rx_state = RX_STOP;
						if (!st.ctrl[NBS_RX_DONE_BIT] && (!st.ctrl[NBS_FILTER_BIT] || ninth))
						begin
							next_st.rx_buf = nbs_rev8(st.rx_shift[7:0]);
							hw_rx_ninth = 1'b1;
							hw_rx_done = 1'b1;
						end
					end
				end
			end
			RX_STOP:
			begin
				if (rx_roll)
				begin
					next_st.rx_state = RX_IDLE;
				end
			end
			default:
			begin
				next_st.rx_state = RX_IDLE;
			end
		endcase

		// register writes; a hardware set beats a software clear
		if (access_wr)
		begin
			case (paddr)
				NBS_CTRL_OFF:
				begin
					next_st.ctrl = pwdata[7:0];
				end
				NBS_BUF_OFF:
				begin
					next_st.tx_shift = {st.ctrl[NBS_TX_NINTH_BIT], pwdata[7:0]};
					next_st.tx_pend = 1'b1;
					next_st.tx_send = 1'b0;
					next_st.tx_data = 1'b0;
				end
				NBS_RATE_OFF:
				begin
					next_st.rate_double = pwdata[NBS_RATE_DOUBLE_BIT];
				end
				default:
				begin
					next_st.err = 1'b0;
				end
			endcase
		end
		if (hw_rx_ninth)
		begin
			next_st.ctrl[NBS_RX_NINTH_BIT] = ninth;
		end
		if (hw_rx_done)
		begin
			next_st.ctrl[NBS_RX_DONE_BIT] = 1'b1;
		end
		if (hw_tx_done)
		begin
			next_st.ctrl[NBS_TX_DONE_BIT] = 1'b1;
		end

		// line level: start bit, shifter output, otherwise idle high
		if (next_st.tx_send)
		begin
			next_st.txd = next_st.tx_data ? next_st.tx_shift[0] : NBS_START_LEVEL;
		end
		else
		begin
			next_st.txd = NBS_STOP_LEVEL;
		end

		// read data and error captured in the setup phase
		if (setup_phase)
		begin
			next_st.rdata = 32'h0000_0000;
			next_st.err = ~nbs_mapped(paddr);
			if (!pwrite)
			begin
				case (paddr)
					NBS_CTRL_OFF:
					begin
						next_st.rdata[7:0] = st.ctrl;
					end
					NBS_BUF_OFF:
					begin
						next_st.rdata[7:0] = st.rx_buf;
					end
					NBS_RATE_OFF:
					begin
						next_st.rdata[NBS_RATE_DOUBLE_BIT] = st.rate_double;
					end
					NBS_STAT_OFF:
					begin
						next_st.rdata[NBS_STAT_TX_ACTIVE_BIT] = st.tx_send;
						next_st.rdata[NBS_STAT_RX_ACTIVE_BIT] = (st.rx_state != RX_IDLE);
						next_st.rdata[NBS_STAT_TX_PEND_BIT] = st.tx_pend;
					end
					default:
					begin
						next_st.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.ctrl <= NBS_CTRL_RST;
			st.rate_double <= NBS_RATE_DOUBLE_RST;
			st.rx_buf <= NBS_BUF_RST;
			st.sync1 <= 1'b1;
			st.sync2 <= 1'b1;
			st.sync3 <= 1'b1;
			st.rx_line <= 1'b1;
			st.rx_prev <= 1'b1;
			st.rx_state <= RX_IDLE;
			st.txd <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// outputs
	assign prdata = st.rdata;
	assign pslverr = st.err & psel & penable;
	assign pready = 1'b1;
	assign txd = st.txd;
	assign serial_irq = st.ctrl[NBS_RX_DONE_BIT] | st.ctrl[NBS_TX_DONE_BIT];

endmodule

/* File: sim/nbs_monitor.sv */
// checker: port-level assertions of the nine-bit serial port
`timescale 1ns/1ps
module nbs_monitor
import nbs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic serial_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase, address decode and control writes
	logic acc;
	logic hit;
	logic ctl_wr;
	assign acc = psel && penable;
	assign hit = paddr inside {NBS_CTRL_OFF, NBS_BUF_OFF, NBS_RATE_OFF, NBS_STAT_OFF};
	assign ctl_wr = acc && pwrite && paddr == NBS_CTRL_OFF;
	sequence s_buf_wr;
		acc && pwrite && paddr == NBS_BUF_OFF;
	endsequence
	sequence s_fall;
		txd ##1 !txd;
	endsequence
	a_ready_always: assert property (pready) else $error("pready low");
	a_err_unmapped: assert property (acc && !hit |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped");
	a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("error on mapped");
	a_flag_set: assert property (ctl_wr && pwdata[1:0] != 2'b00 |=> serial_irq) else $error("no irq");
	a_flag_clear: assert property (ctl_wr && pwdata[1:0] == 2'b00 |=> !serial_irq) else $error("irq");
	a_irq_holds: assert property (serial_irq && !ctl_wr |=> serial_irq) else $error("irq dropped");
	a_tx_starts: assert property (s_buf_wr |-> ##[1:200] !txd) else $error("no start bit");
	a_low_width: assert property (s_fall |-> !txd [*8]) else $error("short low");
	a_bit_stable: assert property ($changed(txd) |=> $stable(txd) [*8]) else $error("short bit");
endmodule
bind nbs_serial_port nbs_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.txd(txd), .serial_irq(serial_irq));

/* File: sim/nbs_peer.sv */
// peer serial node: drives frames on rxd, decodes frames seen on txd
`timescale 1ns/1ps
module nbs_peer
(
	input wire logic pclk,
	input wire logic txd,
	output logic rxd
);
	int bit_cycles = 32;
	logic [9:0] got;
	// frame out: start, eight lsb first, ninth, stop, one idle bit time
	task automatic send(input logic [8:0] w, input logic stop);
		logic [11:0] f;
		f = {1'b1, stop, w, 1'b0};
		for (int i = 0; i < 12; i++)
		begin
			rxd <= f[i];
			repeat (bit_cycles) @(posedge pclk);
		end
	endtask
	// low pulse far shorter than the sample points
	task automatic glitch();
		rxd <= 1'b0;
		repeat (4) @(posedge pclk);
		rxd <= 1'b1;
		repeat (2 * bit_cycles) @(posedge pclk);
	endtask
	// frame in: mid-bit samples after each falling edge
	initial
	begin
		rxd = 1'b1;
		forever
		begin
			@(negedge txd);
			repeat (bit_cycles / 2) @(posedge pclk);
			for (int i = 0; i < 10; i++)
			begin
				repeat (bit_cycles) @(posedge pclk);
				got[i] = txd;
			end
		end
	end
endmodule

/* File: sim/tb_top.sv */
// testbench: apb register tests with a serial peer on the line
`timescale 1ns/1ps
module tb_top;
	import nbs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer1_overflow = 1'b0;
	logic rxd;
	logic txd;
	logic serial_irq;
	logic [1:0] ovf_cnt = 2'h0;
	int bad_count = 0;
	int checked = 0;
	logic last_err = 1'b0;
	logic [7:0] ctl [4] = '{8'h98, 8'h90, 8'hd8, 8'hd0};
	int bits [4] = '{32, 64, 48, 96};
	nbs_serial_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer1_overflow(timer1_overflow), .rxd(rxd), .txd(txd), .serial_irq(serial_irq));
	nbs_peer i_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
	initial forever #20 pclk = ~pclk;
	// timer 1 overflow every third cycle
	always @(posedge pclk)
	begin
		ovf_cnt <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
		timer1_overflow <= (ovf_cnt == 2'h2);
	end
	// one apb transfer: setup, access until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input string name, input logic [7:0] e);
		logic [31:0] q;
		apb(1'b0, a, 8'h00, q);
		check(name, q, {24'h00_0000, e});
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog against a hang
	initial
	begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		end_sim();
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, read-only status, unmapped place, software flags
		rd(NBS_CTRL_OFF, "ctrl reset", 8'h00);
		rd(NBS_BUF_OFF, "buf reset", 8'h00);
		rd(NBS_RATE_OFF, "rate reset", 8'h00);
		wr(NBS_STAT_OFF, 8'hff);
		rd(NBS_STAT_OFF, "stat ro", 8'h00);
		check("mapped err", 32'(last_err), 32'h0000_0000);
		wr(12'h010, 8'hff);
		rd(12'h010, "unmapped", 8'h00);
		check("unmapped err", 32'(last_err), 32'h0000_0001);
		wr(NBS_CTRL_OFF, 8'h92);
		#1 check("sw irq set", 32'(serial_irq), 32'h0000_0001);
		wr(NBS_CTRL_OFF, 8'h90);
		#1 check("sw irq clear", 32'(serial_irq), 32'h0000_0000);
		$display("test registers done");
		// receive: accept, busy drop, filter drop, glitch, stop ignored, disabled
		wr(NBS_RATE_OFF, 8'h01);
		i_peer.send(9'h13c, 1'b1);
		rd(NBS_BUF_OFF, "rx byte", 8'h3c);
		rd(NBS_CTRL_OFF, "rx flags", 8'h95);
		i_peer.send(9'h055, 1'b1);
		rd(NBS_BUF_OFF, "busy drop", 8'h3c);
		wr(NBS_CTRL_OFF, 8'hb0);
		i_peer.send(9'h077, 1'b1);
		rd(NBS_CTRL_OFF, "filter drop", 8'hb0);
		i_peer.glitch();
		i_peer.send(9'h181, 1'b0);
		rd(NBS_BUF_OFF, "stop ignored", 8'h81);
		rd(NBS_CTRL_OFF, "filter pass", 8'hb5);
		wr(NBS_CTRL_OFF, 8'h80);
		i_peer.send(9'h1ee, 1'b1);
		rd(NBS_CTRL_OFF, "rx off", 8'h80);
		$display("test receive done");
		// transmit at fosc/32, fosc/64 and both timer 1 rates
		for (int k = 0; k < 4; k++)
		begin
			i_peer.bit_cycles = bits[k];
			wr(NBS_RATE_OFF, {7'h00, ~k[0]});
			wr(NBS_CTRL_OFF, ctl[k]);
			wr(NBS_BUF_OFF, ctl[k]);
			repeat (200) if (txd !== 1'b0) @(posedge pclk);
			rd(NBS_STAT_OFF, "tx active", 8'h01);
			repeat (1500) if (serial_irq !== 1'b1) @(posedge pclk);
			repeat (bits[k]) @(posedge pclk);
			check("tx frame", 32'(i_peer.got), 32'({1'b1, ctl[k][3], ctl[k]}));
			rd(NBS_CTRL_OFF, "tx done", ctl[k] | 8'h02);
			check("tx idle", 32'(txd), 32'h0000_0001);
			wr(NBS_CTRL_OFF, ctl[k] & 8'hfc);
		end
		$display("test transmit done");
		end_sim();
	end
endmodule
